//--- core/trim_pkg.sv
// shared constants and helpers for the trim option byte bank
package trim_pkg;

    // word index of each trim byte; byte address is four times the index
    localparam logic [2:0] IDX_RSVD_ZERO = 3'h0;
    localparam logic [2:0] IDX_RSVD_ONE = 3'h1;
    localparam logic [2:0] IDX_OSC_TRIM = 3'h2;
    localparam logic [2:0] IDX_LOW_VOLTAGE_TRIM_CODE = 3'h3;
    localparam logic [2:0] IDX_RSVD_FOUR = 3'h4;
    // read-only status word holding the computed threshold
    localparam logic [2:0] IDX_STATUS = 3'h5;
    localparam logic [2:0] IDX_LAST_TRIM = 3'h4;

    // index field inside the bus address
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 3;

    // information page locations backing the trim bytes
    localparam logic [7:0] INFO_BASE = 8'h20;
    localparam logic [7:0] INFO_LAST = 8'h24;

    // low voltage byte layout
    localparam int LVD_CODE_LSB = 0;
    localparam int LVD_CODE_MSB = 4;
    localparam int LVD_RSVD_LSB = 5;
    localparam int LVD_RSVD_MSB = 7;
    localparam logic [2:0] LVD_RSVD_ONES = 3'h7;
    localparam logic [4:0] LVD_DEFAULT_CODE = 5'h0a;
    localparam logic [7:0] LVD_FACTORY_BYTE = {LVD_RSVD_ONES, LVD_DEFAULT_CODE};

    // threshold arithmetic in millivolts
    localparam logic [11:0] THR_BASE_MV = 12'he10;
    localparam logic [11:0] THR_STEP_MV = 12'h032;
    localparam int THR_W = 12;

    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic HRESP_OKAY = 1'b0;

    // trim index to information page location
    function automatic logic [7:0] info_addr(input logic [2:0] idx);
        info_addr = INFO_BASE + {5'h00, idx};
    endfunction

    // nominal threshold for a trim code
    function automatic logic [11:0] threshold_mv(input logic [4:0] code);
        logic [11:0] step;
        step = 12'({7'h00, code} * THR_STEP_MV);
        threshold_mv = THR_BASE_MV - step;
    endfunction

endpackage

//--- core/trim_ahb_slave.sv
// ahb-lite front end for the trim byte bank
`timescale 1ns/1ps
`default_nettype none
module trim_ahb_slave #(
    parameter int HADDR_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic wr_en,
    output logic [trim_pkg::IDX_W-1:0] wr_idx,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [trim_pkg::IDX_W-1:0] rd_idx,
    output logic rd_hit
);
    import trim_pkg::*;

    // the index field must fit inside the address
    if (HADDR_W < IDX_LSB + IDX_W + 1) begin : g_addr_chk
        $error("haddr too narrow for the trim map");
    end

    logic take; // address phase accepted this edge
    logic hit; // address lands on a mapped word
    logic [IDX_W-1:0] idx; // word index of this address phase
    logic wr_pend_q; // write data phase in progress
    logic [IDX_W-1:0] wr_idx_q; // index held into the data phase

    // decode: upper address bits must be clear and index in range
    always_comb begin
        idx = haddr[IDX_LSB +: IDX_W];
        take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && (hsize == HSIZE_WORD);
        if (haddr[HADDR_W-1:IDX_LSB+IDX_W] != '0) begin
            hit = 1'b0;
        end else if (haddr[IDX_LSB-1:0] != '0) begin
            hit = 1'b0;
        end else if (idx <= IDX_STATUS) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // registers answer at once, so no wait states and never an error
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    // reads are sampled in the address phase; the main file bypasses writes
    assign rd_en = take && !hwrite;
    assign rd_idx = idx;
    assign rd_hit = hit;

    // writes only to trim bytes; status word and holes swallow the data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= '0;
        end else begin
            wr_pend_q <= take && hwrite && hit && (idx <= IDX_LAST_TRIM);
            wr_idx_q <= idx;
        end
    end

    assign wr_en = wr_pend_q;
    assign wr_idx = wr_idx_q;
    assign wr_data = hwdata[7:0];

endmodule
`default_nettype wire

//--- core/trim_option_bytes.sv
// trim option byte bank with ahb-lite access and analog control words
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - trim words 0-4 map to info 20h-24h
// - bytes read/write, untouched by any reset
// - whole byte 2 trims the oscillator
// - byte 3 bits 4:0 hold threshold code
// - each code step lowers threshold one step
// - threshold is base minus code times step
// - factory default code is 01010, 3.10 V
module trim_option_bytes #(
    parameter int HADDR_W = 32,
    parameter logic [7:0] OSC_FACTORY_BYTE = 8'h80,
    parameter logic [7:0] RSVD_FACTORY_BYTE = 8'hff
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic nv_init,
    input wire logic hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] oscillator_trim_value,
    output logic [4:0] low_voltage_trim_code,
    output logic [trim_pkg::THR_W-1:0] low_voltage_threshold
);
    import trim_pkg::*;

    // the map assumes exactly five bytes behind 20h-24h
    if (INFO_LAST - INFO_BASE != 8'(IDX_LAST_TRIM)) begin : g_map_chk
        $error("information page window does not match trim count");
    end

    logic wr_en; // write data phase, one cycle
    logic [IDX_W-1:0] wr_idx; // target of that write
    logic [7:0] wr_data; // byte being written
    logic rd_en; // read address phase, one cycle
    logic [IDX_W-1:0] rd_idx; // word asked for
    logic rd_hit; // word is mapped

    // nonvolatile image, addressed by information page location
    logic [7:0] trim_mem [INFO_BASE:INFO_LAST];

    logic [31:0] hrdata_q; // read data for the data phase
    logic [7:0] osc_q; // oscillator control word
    logic [4:0] lvd_code_q; // threshold trim code
    logic [THR_W-1:0] thr_q; // nominal threshold in mV
    logic [7:0] rd_byte; // selected byte with write bypass

    // bus front end
    trim_ahb_slave #(
        .HADDR_W(HADDR_W)
    ) u_bus (
        .clk(clk),
        .sys_rst(sys_rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_hit(rd_hit)
    );

    // storage has no reset branch on purpose: bus reset must not disturb
    // the trim image; only the power-on load pulse restores factory values
    always_ff @(posedge clk) begin
        if (nv_init) begin
            // factory image, default threshold code included
            trim_mem[info_addr(IDX_RSVD_ZERO)] <= RSVD_FACTORY_BYTE;
            trim_mem[info_addr(IDX_RSVD_ONE)] <= RSVD_FACTORY_BYTE;
            trim_mem[info_addr(IDX_OSC_TRIM)] <= OSC_FACTORY_BYTE;
            trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)] <= LVD_FACTORY_BYTE;
            trim_mem[info_addr(IDX_RSVD_FOUR)] <= RSVD_FACTORY_BYTE;
        end else if (wr_en) begin
            // reserved bits are stored exactly as written, no masking
            trim_mem[info_addr(wr_idx)] <= wr_data;
        end
    end

    // read mux; a write finishing this cycle to the same word wins,
    // which keeps back-to-back write then read coherent at zero wait
    always_comb begin
        if (wr_en && (wr_idx == rd_idx)) begin
            rd_byte = wr_data;
        end else if (rd_idx <= IDX_LAST_TRIM) begin
            rd_byte = trim_mem[info_addr(rd_idx)];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // read data register, loaded in the address phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= RDATA_RESET;
        end else if (rd_en) begin
            if (!rd_hit) begin
                // unmapped words read zero
                hrdata_q <= RDATA_RESET;
            end else if (rd_idx == IDX_STATUS) begin
                // status word exposes the computed threshold
                hrdata_q <= {20'h00000, thr_q};
            end else begin
                hrdata_q <= {24'h000000, rd_byte};
            end
        end
    end

    assign hrdata = hrdata_q;

    // oscillator word follows storage one cycle later;
    // reset shows factory values until the copy takes over
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_q <= OSC_FACTORY_BYTE;
        end else begin
            osc_q <= trim_mem[info_addr(IDX_OSC_TRIM)];
        end
    end

    // threshold code uses only the low field; upper bits are ignored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvd_code_q <= LVD_DEFAULT_CODE;
        end else begin
            lvd_code_q <= trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)][LVD_CODE_MSB:LVD_CODE_LSB];
        end
    end

    // threshold derived from the latched code, a further cycle behind
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            thr_q <= threshold_mv(LVD_DEFAULT_CODE);
        end else begin
            thr_q <= threshold_mv(lvd_code_q);
        end
    end

    // analog consumers see static words, never bus glitches
    assign oscillator_trim_value = osc_q;
    assign low_voltage_trim_code = lvd_code_q;
    assign low_voltage_threshold = thr_q;

    // helper: trim bytes as last seen before a reset pulse
    logic [7:0] snap_osc_q;
    logic [7:0] snap_lvd_q;
    logic snap_ok_q; // snapshot taken since the last image load
    logic rst_seen_q; // reset level one edge back

    // the snapshot also runs on the first edge inside reset, so a write
    // landing on the very edge that reset rises is still captured
    always_ff @(posedge clk) begin
        rst_seen_q <= sys_rst;
        if (nv_init) begin
            // image reload makes any older snapshot meaningless
            snap_ok_q <= 1'b0;
        end else if (!rst_seen_q) begin
            snap_osc_q <= trim_mem[info_addr(IDX_OSC_TRIM)];
            snap_lvd_q <= trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)];
            snap_ok_q <= 1'b1;
        end
    end

    // write data phase to a control byte with no image load in that cycle
    sequence osc_write_s;
        wr_en && (wr_idx == IDX_OSC_TRIM) && !nv_init;
    endsequence

    sequence lvd_write_s;
        wr_en && (wr_idx == IDX_LOW_VOLTAGE_TRIM_CODE) && !nv_init;
    endsequence

    // a write to word four lands at its information page slot 24h
    map_slot_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_en && (wr_idx == IDX_RSVD_FOUR) && !nv_init
        |=> trim_mem[INFO_LAST] == $past(wr_data)
    ) else $error("trim word four missed information slot 24h");

    // storage survives a reset pulse; no snapshot exists before the first one
    keep_reset_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) && snap_ok_q && !nv_init
        |-> (trim_mem[info_addr(IDX_OSC_TRIM)] == snap_osc_q)
            && (trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)] == snap_lvd_q)
    ) else $error("trim storage changed across reset");

    // an oscillator byte read with no write pending returns the stored byte next cycle
    read_back_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_hit && (rd_idx == IDX_OSC_TRIM) && !wr_en
        |=> hrdata == {24'h000000, $past(trim_mem[info_addr(IDX_OSC_TRIM)])}
    ) else $error("oscillator byte read back wrong");

    // whole byte reaches the oscillator two cycles after the write phase
    osc_word_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        osc_write_s ##1 !nv_init
        |=> oscillator_trim_value == $past(wr_data, 2)
    ) else $error("oscillator word did not follow write");

    // only the low five bits become the code
    lvd_field_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        lvd_write_s ##1 !nv_init
        |=> low_voltage_trim_code == $past(wr_data[LVD_CODE_MSB:LVD_CODE_LSB], 2)
    ) else $error("threshold code not taken from bits 4:0");

    // a higher code always gives a lower threshold one cycle later
    thr_step_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !$stable(low_voltage_trim_code) && (low_voltage_trim_code > $past(low_voltage_trim_code))
        |=> low_voltage_threshold < $past(low_voltage_threshold)
    ) else $error("threshold did not drop for larger code");

    // threshold equals base minus code times step
    thr_value_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !$fell(sys_rst)
        |-> low_voltage_threshold == THR_BASE_MV - 12'({7'h00, $past(low_voltage_trim_code)} * THR_STEP_MV)
    ) else $error("threshold arithmetic wrong");

    // first edge after reset shows the default code and 3100 mV
    reset_default_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst)
        |-> (low_voltage_trim_code == LVD_DEFAULT_CODE) && (low_voltage_threshold == 12'hc1c)
    ) else $error("reset default threshold code wrong");

    // factory load writes the default code and reserved ones
    factory_lvd_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        nv_init |=> trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)] == {LVD_RSVD_ONES, LVD_DEFAULT_CODE}
    ) else $error("factory image missing default code");

    // unmapped reads return zero
    hole_zero_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && !rd_hit |=> hrdata == 32'h0000_0000
    ) else $error("unmapped read not zero");

    // status word read returns the threshold standing at the address phase
    status_read_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_hit && (rd_idx == IDX_STATUS)
        |=> hrdata == {20'h00000, $past(low_voltage_threshold)}
    ) else $error("status word does not show the threshold");

    // reserved top bits of the threshold byte are kept exactly as written
    lvd_rsvd_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        lvd_write_s
        |=> trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)][LVD_RSVD_MSB:LVD_RSVD_LSB]
            == $past(wr_data[LVD_RSVD_MSB:LVD_RSVD_LSB])
    ) else $error("reserved bits of threshold byte altered");

    // quiet storage keeps the threshold code static; the first edge
    // after reset is skipped since the code then leaves its reset value
    code_static_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !$fell(sys_rst) && $stable(trim_mem[info_addr(IDX_LOW_VOLTAGE_TRIM_CODE)])
        |=> $stable(low_voltage_trim_code)
    ) else $error("threshold code moved with storage unchanged");

    // quiet storage keeps the oscillator word static
    osc_static_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !$fell(sys_rst) && $stable(trim_mem[info_addr(IDX_OSC_TRIM)])
        |=> $stable(oscillator_trim_value)
    ) else $error("oscillator word moved with storage unchanged");

    // status word is read only: a write to it never reaches storage
    status_ro_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        hsel && htrans[HTRANS_ACTIVE_BIT] && hready && hwrite
            && (haddr[IDX_LSB +: IDX_W] == IDX_STATUS)
        |=> !wr_en
    ) else $error("write to status word reached storage");

    // read data stands until the next read address phase
    rdata_hold_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !rd_en |=> $stable(hrdata)
    ) else $error("read data changed without a read");

    // trim byte reads are zero extended to the bus width
    byte_pad_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && rd_hit && (rd_idx <= IDX_LAST_TRIM)
        |=> hrdata[31:8] == 24'h000000
    ) else $error("trim byte read not zero extended");

endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the trim option byte bank over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import trim_pkg::*;

    // factory image bytes handed to the design, arbitrary plain values
    localparam logic [7:0] OSC_INIT = 8'h80;
    localparam logic [7:0] RSVD_INIT = 8'hff;
    // cycle ceiling, the whole run needs about a hundred cycles
    localparam int CEIL = 5000;

    logic clk = 1'b0; // 250 MHz system clock
    logic sys_rst = 1'b1; // async reset, active high
    logic nv_init = 1'b0; // factory image load pulse
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready; // single slave, so its hreadyout is the bus ready
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [7:0] oscillator_trim_value;
    wire logic [4:0] low_voltage_trim_code;
    wire logic [11:0] low_voltage_threshold;
    int fail_count = 0; // mismatches seen
    int num_checks = 0; // comparisons made
    int cycles = 0; // cycles since time zero
    logic [31:0] rd; // last read data

    // one row: address, write data, expected read back
    typedef struct {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } row_s;
    // reserved bytes are rewritten with their image value only, so software never alters them
    row_s rows [9] = '{
        '{32'h0000_0000, 32'h0000_00ff, 32'h0000_00ff},
        '{32'h0000_0004, 32'h0000_00ff, 32'h0000_00ff},
        '{32'h0000_0010, 32'h0000_00ff, 32'h0000_00ff},
        '{32'h0000_0008, 32'hdead_be5a, 32'h0000_005a},
        '{32'h0000_0008, 32'h0000_00a5, 32'h0000_00a5},
        '{32'h0000_000c, 32'h0000_00e0, 32'h0000_00e0},
        '{32'h0000_000c, 32'h0000_00ff, 32'h0000_00ff},
        '{32'h0000_000c, 32'h0000_00f5, 32'h0000_00f5},
        '{32'h0000_000c, 32'h0000_00ea, 32'h0000_00ea}
    };

    assign hready = hreadyout;

    trim_option_bytes #(
        .HADDR_W(32),
        .OSC_FACTORY_BYTE(OSC_INIT),
        .RSVD_FACTORY_BYTE(RSVD_INIT)
    ) u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .nv_init(nv_init),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .oscillator_trim_value(oscillator_trim_value),
        .low_voltage_trim_code(low_voltage_trim_code),
        .low_voltage_threshold(low_voltage_threshold)
    );

    // clock: invert every half period of 2 ns
    always #2 clk = ~clk;

    // hang guard: a run past the ceiling counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            test_done();
        end
    end

    // nominal threshold in mV worked out from base minus code times step
    function automatic logic [11:0] thr_exp(input logic [4:0] code);
        return 12'(3600 - 50 * int'(code));
    endfunction

    // compare and count; case inequality so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t value mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    // wait for hready sampled high at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            $display("BAD %0t no ready", $time);
        end
    endtask

    // one single transfer; entered just after a rising edge
    task automatic xfer(input logic [31:0] addr, input logic wr, input logic [2:0] size,
                        input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= size;
        wait_ready();
        // data phase: address released, write data on
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    // verdict and end of run, the only place the run stops
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        // reset for six cycles, image loaded while reset holds
        repeat (2) @(posedge clk);
        nv_init <= 1'b1;
        @(posedge clk);
        nv_init <= 1'b0;
        repeat (3) @(posedge clk);
        check({24'h0, oscillator_trim_value}, {24'h0, OSC_INIT});
        check({27'h0, low_voltage_trim_code}, 32'h0000_000a);
        check({20'h0, low_voltage_threshold}, {20'h0, thr_exp(5'h0a)});
        sys_rst <= 1'b0;
        // image contents visible on the bus right after release
        xfer(32'h0000_000c, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, {24'h0, 3'h7, 5'h0a});
        xfer(32'h0000_0000, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, {24'h0, RSVD_INIT});
        $display("test reset image done");

        // ordinary rows: write, read back, control words follow
        foreach (rows[i]) begin
            xfer(rows[i].addr, 1'b1, HSIZE_WORD, rows[i].wdata, rd);
            xfer(rows[i].addr, 1'b0, HSIZE_WORD, 32'h0, rd);
            check(rd, rows[i].rexp);
            // threshold settles two edges behind storage
            repeat (2) @(posedge clk);
            if (rows[i].addr == 32'h0000_0008) begin
                check({24'h0, oscillator_trim_value}, rows[i].rexp);
            end
            if (rows[i].addr == 32'h0000_000c) begin
                check({27'h0, low_voltage_trim_code}, {27'h0, rows[i].rexp[4:0]});
                check({20'h0, low_voltage_threshold}, {20'h0, thr_exp(rows[i].rexp[4:0])});
                xfer(32'h0000_0014, 1'b0, HSIZE_WORD, 32'h0, rd);
                check(rd, {20'h0, thr_exp(rows[i].rexp[4:0])});
            end
        end
        $display("test rows done");

        // ignored accesses: byte size, unmapped word, status write
        xfer(32'h0000_0008, 1'b1, 3'h0, 32'h0000_0011, rd);
        xfer(32'h0000_0018, 1'b1, HSIZE_WORD, 32'h0000_0022, rd);
        xfer(32'h0000_0014, 1'b1, HSIZE_WORD, 32'h0000_0033, rd);
        xfer(32'h0000_0008, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, 32'h0000_00a5);
        xfer(32'h0000_0018, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, 32'h0000_0000);
        xfer(32'h0000_0014, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, {20'h0, thr_exp(5'h0a)});
        $display("test ignored accesses done");

        // storage survives a mid-run reset, control words reload from it
        xfer(32'h0000_0008, 1'b1, HSIZE_WORD, 32'h0000_0033, rd);
        xfer(32'h0000_000c, 1'b1, HSIZE_WORD, 32'h0000_00e3, rd);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        check({24'h0, oscillator_trim_value}, {24'h0, OSC_INIT});
        check({27'h0, low_voltage_trim_code}, 32'h0000_000a);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        check({24'h0, oscillator_trim_value}, 32'h0000_0033);
        check({27'h0, low_voltage_trim_code}, 32'h0000_0003);
        check({20'h0, low_voltage_threshold}, {20'h0, thr_exp(5'h03)});
        xfer(32'h0000_0008, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, 32'h0000_0033);
        $display("test reset keeps storage done");

        // image reload outside reset restores the factory bytes
        nv_init <= 1'b1;
        @(posedge clk);
        nv_init <= 1'b0;
        repeat (3) @(posedge clk);
        check({24'h0, oscillator_trim_value}, {24'h0, OSC_INIT});
        check({27'h0, low_voltage_trim_code}, 32'h0000_000a);
        check({20'h0, low_voltage_threshold}, {20'h0, thr_exp(5'h0a)});
        xfer(32'h0000_000c, 1'b0, HSIZE_WORD, 32'h0, rd);
        check(rd, {24'h0, 3'h7, 5'h0a});
        $display("test image reload done");
        test_done();
    end
endmodule
`default_nettype wire
